// ---- ewc_consts.svh ----
// Constant definitions for the command decoder for writes to one-time-programmable memory.
`ifndef EWC_CONSTS_SVH
`define EWC_CONSTS_SVH
// Setup packet framing.
`define EWC_REQ_TYPE_VENDOR_OUT 8'h40
`define EWC_WLENGTH_NONE        16'h0000
// Low byte of the value field, write command.
`define EWC_WR_OP_HI            7:4
`define EWC_WR_OP_CODE          4'hc
`define EWC_WR_ZERO_VERIFY      3
`define EWC_WR_ONE_BIT          2
`define EWC_WR_ZERO_BIT         1
`define EWC_IMMEDIATE           0
// High byte of the value field, write command.
`define EWC_HB_CRC_TYPE         5
`define EWC_HB_CLEAR_ON_ERR     3
`define EWC_HB_RESULT_INHIBIT   1
`define EWC_HB_ALLOWED          8'h2a
// Register offsets.
`define EWC_OFS_CTRL            8'h00
`define EWC_OFS_STATUS          8'h04
`define EWC_OFS_CRC             8'h08
`define EWC_OFS_COUNT           8'h0c
// Control and status bit positions.
`define EWC_CTRL_COMPAT         0
`define EWC_CTRL_CLR_STICKY     1
`define EWC_ST_REJECT           0
`define EWC_ST_VERIFY_FAIL      1
`define EWC_ST_BUSY             2
`define EWC_ST_HEAD_VALID       3
`define EWC_ST_TAIL_VALID       4
// Initial CRC values and 16-bit constants.
`define EWC_CRC8_INIT           8'h00
`define EWC_CRC16_INIT          16'h0000
`define EWC_ZERO16              16'h0000
`define EWC_ONE16               16'h0001
`endif

// ---- ewc_pkg.sv ----
// Types shared by the command decoder for writes to one-time-programmable memory.
package ewc_pkg;
  // One control setup packet as seen by the decoder.
  typedef struct packed {
    logic [7:0]  req_type;    // Request type byte.
    logic [7:0]  request;     // Request code byte.
    logic [15:0] value;       // Value field.
    logic [15:0] index;       // Index field.
    logic [15:0] length;      // Data stage length.
  } ewc_setup_type;
  // Kind of command handed to the bus engine.
  typedef enum logic [0:0] {
    EWC_KIND_WRITE = 1'b0,    // Memory write with read-back verify.
    EWC_KIND_PAGE  = 1'b1     // Page read with CRC.
  } ewc_kind_type;
  // Decoded command record.
  typedef struct packed {
    ewc_kind_type kind;              // Command kind.
    logic         crc_type_select;   // High for the 16-bit CRC.
    logic         zero_verify;       // Compare zero bits only.
    logic         execute_immediately; // Run at once.
    logic         clear_on_error;    // Flush on error.
    logic         result_inhibit;    // Suppress result report.
    logic         secure_token_compat; // Token register and buffer access.
    logic [15:0]  byte_count;        // Bytes to move.
  } ewc_cmd_type;
  // Progress of the command being run.
  typedef enum logic [1:0] {
    EWC_IDLE = 2'b00,         // Waiting for a command.
    EWC_RUN  = 2'b01,         // Bytes in flight.
    EWC_DONE = 2'b11          // Reporting the result.
  } ewc_state_type;
  // All state of the decoder.
  typedef struct packed {
    ewc_cmd_type   head;      // Buffer entry toward the engine.
    ewc_cmd_type   tail;      // Second buffer entry.
    logic          head_v;    // Head entry valid.
    logic          tail_v;    // Tail entry valid.
    logic          ready;     // Room for a setup packet.
    ewc_state_type st;        // Run state.
    ewc_cmd_type   act;       // Command being run.
    logic [15:0]   left;      // Bytes still to check.
    logic [15:0]   crc;       // Running CRC.
    logic          fail;      // Verify mismatch in this command.
    logic          reject;    // Sticky malformed packet.
    logic          vfail;     // Sticky verify failure.
    logic          compat;    // Token compatibility control.
    logic [15:0]   count;     // Accepted commands.
    logic [31:0]   rdata;     // Read data.
    logic          res_v;     // Result pulse.
    logic          res_fail;  // Result verify outcome.
    logic          bad;       // Reject pulse.
  } ewc_state_rec_type;
endpackage

// ---- ewc_decoder.sv ----
// Decoder of the memory-write control request, with read-back verify and CRC.
//
// Behaviour
// - CRC flag picks 16-bit, else 8-bit CRC
// - Zero-verify compares only bits written as zero
// - Low value byte holds opcode and flags
// - High index byte is count high byte
// - Low index byte is count low byte
// - Page read serves token registers when compat
//
// Packets queue in a two-entry buffer.
// Commands leave for the engine in order.
// Read-back bytes are checked and summed.
// Malformed packets are dropped and flagged.
// The CRC width and verify mode come
// from each command's own flags.
`timescale 1ns/1ps
`default_nettype none
`include "ewc_consts.svh"

module ewc_decoder #(
  parameter logic [7:0]  COMM_REQ_CODE  = 8'h01,  // Request code of communication_request.
  parameter logic [3:0]  PAGE_OP_CODE   = 4'h0,   // Opcode nibble of the page read.
  parameter logic [7:0]  CRC8_POLY      = 8'h8c,  // Reflected 8-bit polynomial.
  parameter logic [15:0] CRC16_POLY     = 16'ha001 // Reflected 16-bit polynomial.
) (
  // Clock and reset.
  input  wire logic                  ref_clk_i,
  input  wire logic                  sys_rst_i,
  // Setup packets from the USB side.
  // The packet must hold while valid waits.
  input  wire logic                  setup_valid_i,
  input  wire ewc_pkg::ewc_setup_type setup_i,
  output var  logic                  setup_ready_o,
  output var  logic                  reject_o,
  // Commands toward the bus engine.
  // A command stands until cmd_ready_i.
  output var  logic                  cmd_valid_o,
  output var  ewc_pkg::ewc_cmd_type  cmd_o,
  input  wire logic                  cmd_ready_i,
  // Bytes read back by the bus engine.
  // Data count only with rb_valid_i high.
  input  wire logic                  rb_valid_i,
  input  wire logic [7:0]            rb_written_i,
  input  wire logic [7:0]            rb_read_i,
  // Result of the command.
  // The pulse is kept back on request.
  output var  logic                  result_valid_o,
  output var  logic                  result_fail_o,
  output var  logic [15:0]           result_crc_o,
  // Register port.
  // Read data come one cycle later.
  input  wire logic [7:0]            reg_addr_i,
  input  wire logic [31:0]           reg_wdata_i,
  input  wire logic                  reg_write_i,
  input  wire logic                  reg_read_i,
  output var  logic [31:0]           reg_rdata_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions.

  // Both CRCs run reflected and shift right.
  // Each loop unrolls into a small xor tree.
  // Every command starts its CRC from zero.
  // The 8-bit CRC sits in the low byte.
  // Its high byte stays zero for software.

  // Advances the 8-bit CRC over one byte, low bit first.
  function automatic logic [7:0] crc8_step(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC8_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // Advances the 16-bit CRC over one byte, low bit first.
  function automatic logic [15:0] crc16_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC16_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // Flags a read-back mismatch; in zero mode bits written as one are ignored.
  // Cells that can only be cleared may read
  // zero where one was written; not an error.
  function automatic logic verify_bad(input logic zero_only, input logic [7:0] w,
                                      input logic [7:0] r);
    logic [7:0] m;
    m = zero_only ? ~w : 8'hff;
    return ((w ^ r) & m) != 8'h00;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State.

  // All registers live in one record, so
  // reset covers every field of state.
  // Next values build on a copy of the
  // registered record, field by field.
  // The helpers below hold no state.

  ewc_pkg::ewc_state_rec_type s_q;  // Registered state.
  ewc_pkg::ewc_state_rec_type s_d;  // Next state.
  ewc_pkg::ewc_cmd_type       dec;  // Decoded packet.
  logic                       ok;   // Packet is a well-formed command.
  logic                       push; // Packet taken this cycle.
  logic                       pop;  // Command handed out this cycle.
  logic                       bad;  // Read-back mismatch this cycle.
  logic [7:0]                 lo;   // Low value byte.
  logic [7:0]                 hi;   // High value byte.

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  // A packet taken at an edge shows as a reject,
  // or as a command if it enters the head, one cycle later.
  // A pop while idle loads the checker.
  // The checker counts the read-back bytes,
  // spends one cycle done, then pulses.
  // A pop while busy goes unchecked, so
  // the engine waits for the result.
  // The result flags hold until the
  // next command reaches its end.
  // Decodes the packet, runs the buffer, the checker and the registers.
  always_comb begin
    s_d  = s_q;
    lo   = setup_i.value[7:0];
    hi   = setup_i.value[15:8];
    dec  = '0;
    // Flags come from fixed field positions.
    dec.crc_type_select     = hi[`EWC_HB_CRC_TYPE];
    dec.clear_on_error      = hi[`EWC_HB_CLEAR_ON_ERR];
    dec.result_inhibit      = hi[`EWC_HB_RESULT_INHIBIT];
    dec.zero_verify         = lo[`EWC_WR_ZERO_VERIFY];
    dec.execute_immediately = lo[`EWC_IMMEDIATE];
    dec.byte_count          = {setup_i.index[15:8], setup_i.index[7:0]};
    // A vendor request with no data stage is the only framing taken.
    ok = (setup_i.req_type == `EWC_REQ_TYPE_VENDOR_OUT) &&
         (setup_i.request == COMM_REQ_CODE) &&
         (setup_i.length == `EWC_WLENGTH_NONE);
    // The opcode nibble picks the kind.
    // Any other nibble is malformed.
    if (lo[`EWC_WR_OP_HI] == `EWC_WR_OP_CODE) begin
      // Write command: fixed bits and reserved high bits must match.
      dec.kind = ewc_pkg::EWC_KIND_WRITE;
      ok = ok && lo[`EWC_WR_ONE_BIT] && !lo[`EWC_WR_ZERO_BIT] &&
           ((hi & ~`EWC_HB_ALLOWED) == 8'h00);
    end else if (lo[`EWC_WR_OP_HI] == PAGE_OP_CODE) begin
      // Page read: token access rides on the compatibility control.
      dec.kind = ewc_pkg::EWC_KIND_PAGE;
      dec.secure_token_compat = s_q.compat;
    end else begin
      ok = 1'b0;
    end
    // Packets enter only while the tail is free.
    push = setup_valid_i && s_q.ready;
    pop  = s_q.head_v && cmd_ready_i;
    // Two-entry buffer: pop shifts the tail forward, push fills the first hole.
    if (pop) begin
      s_d.head   = s_q.tail;
      s_d.head_v = s_q.tail_v;
      s_d.tail_v = 1'b0;
    end
    // A new entry fills the head if empty,
    // else the tail, so order is kept.
    if (push && ok) begin
      if (!s_d.head_v) begin
        s_d.head   = dec;
        s_d.head_v = 1'b1;
      end else begin
        s_d.tail   = dec;
        s_d.tail_v = 1'b1;
      end
      s_d.count = s_q.count + `EWC_ONE16;
    end
    // Ready follows the next tail state.
    // A pop frees room for the next cycle.
    s_d.ready = !s_d.tail_v;
    // Reject and result are one-cycle pulses.
    s_d.bad   = push && !ok;
    s_d.res_v = 1'b0;
    // Mismatch of the byte now on the port.
    bad = verify_bad(s_q.act.zero_verify, rb_written_i, rb_read_i);
    // Only write commands can fail.
    // Run state: one command checked at a time.
    unique case (s_q.st)
      ewc_pkg::EWC_IDLE: begin
        // Load only as the head leaves.
        if (pop) begin
          s_d.act  = s_q.head;
          s_d.left = s_q.head.byte_count;
          s_d.fail = 1'b0;
          s_d.crc  = s_q.head.crc_type_select ? `EWC_CRC16_INIT
                                              : {8'h00, `EWC_CRC8_INIT};
          s_d.st   = ewc_pkg::EWC_RUN;
        end
      end
      ewc_pkg::EWC_RUN: begin
        // No bytes left ends the command.
        if (s_q.left == `EWC_ZERO16) begin
          s_d.st = ewc_pkg::EWC_DONE;
        end else if (rb_valid_i) begin
          // Each read-back byte advances the CRC of the chosen width.
          if (s_q.act.crc_type_select) begin
            s_d.crc = crc16_step(s_q.crc, rb_read_i);
          end else begin
            s_d.crc = {8'h00, crc8_step(s_q.crc[7:0], rb_read_i)};
          end
          // Page reads count but never fail.
          s_d.left = s_q.left - `EWC_ONE16;
          if ((s_q.act.kind == ewc_pkg::EWC_KIND_WRITE) && bad) begin
            s_d.fail = 1'b1;
            if (s_q.act.clear_on_error) begin
              s_d.st = ewc_pkg::EWC_DONE;
            end
          end
        end
      end
      ewc_pkg::EWC_DONE: begin
        // The report is kept back when the command asks for silence.
        s_d.res_v    = !s_q.act.result_inhibit;
        s_d.res_fail = s_q.fail;
        s_d.st       = ewc_pkg::EWC_IDLE;
      end
      default: begin
        // The unused code goes back to idle.
        s_d.st = ewc_pkg::EWC_IDLE;
      end
    endcase
    // Sticky status: hardware set wins over a software clear.
    // Clears come first and sets after,
    // so no event is lost to a clear.
    if (reg_write_i && (reg_addr_i == `EWC_OFS_CTRL)) begin
      // The compat control takes effect next cycle.
      s_d.compat = reg_wdata_i[`EWC_CTRL_COMPAT];
      if (reg_wdata_i[`EWC_CTRL_CLR_STICKY]) begin
        s_d.reject = 1'b0;
        s_d.vfail  = 1'b0;
      end
    end
    if (push && !ok) begin
      s_d.reject = 1'b1;
    end
    // A failed command sets the sticky flag.
    if ((s_q.st == ewc_pkg::EWC_DONE) && s_q.fail) begin
      s_d.vfail = 1'b1;
    end
    // Read data stand only in the cycle after the strobe.
    // Unmapped offsets read as zero.
    s_d.rdata = 32'h0000_0000;
    if (reg_read_i) begin
      unique case (reg_addr_i)
        `EWC_OFS_CTRL:   s_d.rdata[`EWC_CTRL_COMPAT] = s_q.compat;
        `EWC_OFS_STATUS: begin
          s_d.rdata[`EWC_ST_REJECT]      = s_q.reject;
          s_d.rdata[`EWC_ST_VERIFY_FAIL] = s_q.vfail;
          s_d.rdata[`EWC_ST_BUSY]        = s_q.st != ewc_pkg::EWC_IDLE;
          s_d.rdata[`EWC_ST_HEAD_VALID]  = s_q.head_v;
          s_d.rdata[`EWC_ST_TAIL_VALID]  = s_q.tail_v;
        end
        `EWC_OFS_CRC:    s_d.rdata[15:0] = s_q.crc;
        `EWC_OFS_COUNT:  s_d.rdata[15:0] = s_q.count;
        default:         s_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.

  // Registers all state; reset empties the buffer and idles the checker.
  // Reset is synchronous; the buffer is
  // ready at the first edge after release.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      s_q       <= '0;
      s_q.ready <= 1'b1;
      s_q.st    <= ewc_pkg::EWC_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from the state register.

  // No logic follows the register, so
  // outputs are glitch-free at the pins.

  assign setup_ready_o  = s_q.ready;
  assign reject_o       = s_q.bad;
  assign cmd_valid_o    = s_q.head_v;
  assign cmd_o          = s_q.head;
  assign result_valid_o = s_q.res_v;
  assign result_fail_o  = s_q.res_fail;
  assign result_crc_o   = s_q.crc;
  assign reg_rdata_o    = s_q.rdata;

endmodule // ewc_decoder
`default_nettype wire

// ---- ewc_decoder_sva.sv ----
// Assertion checker for the ports of the setup-packet decoder.
`timescale 1ns/1ps
`default_nettype none
module ewc_decoder_sva #(
  parameter logic [7:0] COMM_REQ_CODE = 8'h01, // Request code of a communication request.
  parameter logic [3:0] PAGE_OP_CODE  = 4'h0   // Opcode nibble of a page read.
) (
  // Clock and reset.
  input wire logic                   ref_clk_i,
  input wire logic                   sys_rst_i,
  // Setup packets.
  input wire logic                   setup_valid_i,
  input wire ewc_pkg::ewc_setup_type setup_i,
  input wire logic                   setup_ready_o,
  input wire logic                   reject_o,
  // Commands and results.
  input wire logic                   cmd_valid_o,
  input wire ewc_pkg::ewc_cmd_type   cmd_o,
  input wire logic                   cmd_ready_i,
  input wire logic                   result_valid_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Decoded views of the packet on offer; fresh means the head is empty.
  logic take, frame_ok, op_ok, wr_ok, fresh;
  assign take     = setup_valid_i && setup_ready_o;
  assign frame_ok = setup_i.req_type == 8'h40 && setup_i.request == COMM_REQ_CODE
                    && setup_i.length == 16'h0000;
  assign op_ok    = setup_i.value[7:4] == 4'hc && setup_i.value[2:1] == 2'b10;
  assign wr_ok    = take && frame_ok && op_ok && (setup_i.value[15:8] & 8'hd5) == 8'h00;
  assign fresh    = !cmd_valid_o;
  a_bad_frame: assert property (take && !frame_ok |=> reject_o)
    else $error("malformed frame not rejected");
  a_bad_opcode: assert property (take && frame_ok && setup_i.value[7:4] == 4'hc && !op_ok
    |=> reject_o)
    else $error("bad opcode bits not rejected");
  a_bad_high: assert property (take && frame_ok && op_ok
    && (setup_i.value[15:8] & 8'hd5) != 8'h00 |=> reject_o)
    else $error("bad high value bits not rejected");
  a_count_taken: assert property (wr_ok && fresh |=> cmd_valid_o && !reject_o
    && cmd_o.byte_count == $past(setup_i.index))
    else $error("byte count not taken from index");
  a_crc_flags: assert property (wr_ok && fresh |=> cmd_o.kind == ewc_pkg::EWC_KIND_WRITE
    && cmd_o.crc_type_select == $past(setup_i.value[13])
    && cmd_o.clear_on_error == $past(setup_i.value[11])
    && cmd_o.result_inhibit == $past(setup_i.value[9]))
    else $error("high value flags misplaced");
  a_verify_flags: assert property (wr_ok && fresh |=> cmd_o.zero_verify == $past(setup_i.value[3])
    && cmd_o.execute_immediately == $past(setup_i.value[0]))
    else $error("low value flags misplaced");
  a_page_kind: assert property (take && frame_ok && setup_i.value[7:4] == PAGE_OP_CODE && fresh
    |=> cmd_valid_o && cmd_o.kind == ewc_pkg::EWC_KIND_PAGE)
    else $error("page read not decoded");
  a_head_holds: assert property (cmd_valid_o && !cmd_ready_i |=> cmd_valid_o && $stable(cmd_o))
    else $error("head command changed before pop");
  c_write: cover property (wr_ok);
  c_reject: cover property (reject_o);
  c_result: cover property (result_valid_o);
  c_full: cover property (cmd_valid_o && !setup_ready_o);
endmodule // ewc_decoder_sva
bind ewc_decoder ewc_decoder_sva #(.COMM_REQ_CODE(COMM_REQ_CODE), .PAGE_OP_CODE(PAGE_OP_CODE))
  u_sva (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .setup_valid_i(setup_valid_i),
  .setup_i(setup_i), .setup_ready_o(setup_ready_o), .reject_o(reject_o),
  .cmd_valid_o(cmd_valid_o), .cmd_o(cmd_o), .cmd_ready_i(cmd_ready_i),
  .result_valid_o(result_valid_o));
`default_nettype wire

// ---- ewc_engine_model.sv ----
// Model of the bus engine that takes commands and returns read-back bytes.
`timescale 1ns/1ps
`default_nettype none
module ewc_engine_model (
  // Clock, reset and test controls.
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 hold_i,
  input  wire logic [7:0]           flip_i,
  // Command handshake and read-back bytes.
  input  wire logic                 cmd_valid_i,
  input  wire ewc_pkg::ewc_cmd_type cmd_i,
  output logic                      cmd_ready_o,
  output logic                      rb_valid_o,
  output logic [7:0]                rb_written_o,
  output logic [7:0]                rb_read_o
);
  logic        busy = 1'b0;  // Bytes of a command in flight.
  logic [3:0]  gap  = 4'h0;  // Rest so the decoder is idle before the next pop.
  logic [15:0] n    = 16'h0; // Bytes sent.
  logic [15:0] cnt  = 16'h0; // Bytes to send.
  assign cmd_ready_o = !busy && gap == 4'h0 && !hold_i;
  // One byte a cycle; idle data toggles so a stale byte never passes for a fresh one.
  always @(posedge clk_i) begin
    rb_valid_o <= 1'b0;
    rb_written_o <= ~rb_written_o;
    rb_read_o <= ~rb_read_o;
    if (rst_i) begin
      busy <= 1'b0;
      gap <= 4'h0;
    end else if (busy && n == cnt) begin
      busy <= 1'b0;
      gap <= 4'h8;
    end else if (busy) begin
      rb_valid_o <= 1'b1;
      rb_written_o <= {4'hf, n[3:0]};
      rb_read_o <= {4'hf, n[3:0]} ^ flip_i;
      n <= n + 16'h1;
    end else if (gap != 4'h0) begin
      gap <= gap - 4'h1;
    end else if (cmd_valid_i && cmd_ready_o) begin
      busy <= 1'b1;
      n <= 16'h0;
      cnt <= cmd_i.byte_count;
    end
  end
endmodule // ewc_engine_model
`default_nettype wire

// ---- eprom_write_command_decode_tb.sv ----
// Self-checking testbench of the setup-packet decoder.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module eprom_write_command_decode_tb;
  logic ref_clk_i = 1'b0, sys_rst_i = 1'b1, setup_valid_i = 1'b0, hold = 1'b0;
  logic reg_write_i = 1'b0, reg_read_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00, flip = 8'h00, rb_written_i, rb_read_i;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
  logic setup_ready_o, reject_o, cmd_valid_o, cmd_ready_i, rb_valid_i, result_valid_o;
  logic result_fail_o;
  logic [15:0] result_crc_o;
  ewc_pkg::ewc_setup_type setup_i = '0;
  ewc_pkg::ewc_cmd_type cmd_o;
  int checks = 0, mismatches = 0, n_ok = 0;
  always #12.5 ref_clk_i = ~ref_clk_i;
  ewc_decoder uut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .setup_valid_i(setup_valid_i),
    .setup_i(setup_i), .setup_ready_o(setup_ready_o), .reject_o(reject_o),
    .cmd_valid_o(cmd_valid_o), .cmd_o(cmd_o), .cmd_ready_i(cmd_ready_i),
    .rb_valid_i(rb_valid_i), .rb_written_i(rb_written_i), .rb_read_i(rb_read_i),
    .result_valid_o(result_valid_o), .result_fail_o(result_fail_o),
    .result_crc_o(result_crc_o), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o));
  ewc_engine_model eng (.clk_i(ref_clk_i), .rst_i(sys_rst_i), .hold_i(hold), .flip_i(flip),
    .cmd_valid_i(cmd_valid_o), .cmd_i(cmd_o), .cmd_ready_o(cmd_ready_i),
    .rb_valid_o(rb_valid_i), .rb_written_o(rb_written_i), .rb_read_o(rb_read_i));
  ////////////////////////////////////////////////////////////////////////////////
  // Vendor request with an empty data stage.
  function automatic ewc_pkg::ewc_setup_type pk(input logic [15:0] v, input logic [15:0] n);
    return {8'h40, 8'h01, v, n, 16'h0000};
  endfunction
  // Expected verify outcome and reflected CRC over the bytes the model reads back.
  function automatic logic [16:0] f(input logic sel, zv, input logic [15:0] n,
                                    input logic [7:0] fl);
    logic [15:0] c;
    logic [7:0] w;
    logic bad;
    c = 16'h0000;
    bad = 1'b0;
    for (int i = 0; i < n; i++) begin
      w = {4'hf, 4'(i)};
      bad |= zv ? |(~w & fl) : |fl;
      c[7:0] ^= w ^ fl;
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ (sel ? 16'ha001 : 16'h008c) : c >> 1;
    end
    return {bad, c};
  endfunction
  // Offers a packet until taken, then judges the answer one cycle later.
  task automatic send(input ewc_pkg::ewc_setup_type s, input logic rej, chk);
    setup_i <= s;
    setup_valid_i <= 1'b1;
    do @(negedge ref_clk_i); while (!setup_ready_o);
    @(posedge ref_clk_i);
    setup_valid_i <= 1'b0;
    @(negedge ref_clk_i);
    `CHK(reject_o, rej)
    if (chk) `CHK(cmd_o.byte_count, s.index)
    if (!rej) n_ok++;
    @(posedge ref_clk_i);
  endtask
  task automatic wait_result(input logic [16:0] e);
    int n = 0;
    do begin
      @(negedge ref_clk_i);
      n++;
    end while (!result_valid_o && n < 3000);
    `CHK(result_valid_o, 1'b1)
    `CHK({result_fail_o, result_crc_o}, e)
    @(posedge ref_clk_i);
  endtask
  task automatic run(input logic [15:0] v, n, input logic [7:0] fl);
    flip <= fl;
    send(pk(v, n), 1'b0, 1'b1);
    wait_result(f(v[13], v[3], n, fl));
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_write_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_read_i <= 1'b0;
    @(negedge ref_clk_i);
    `CHK(reg_rdata_o, e)
    @(posedge ref_clk_i);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Both CRC widths, immediate flag, and a count whose high byte is set.
  task automatic t_crc;
    run(16'h20c5, 16'h0003, 8'h00);
    run(16'h00c4, 16'h0005, 8'h00);
    run(16'h00c4, 16'h0102, 8'h00);
    run(16'h00c4, 16'h0000, 8'h00);
    $display("test crc done");
  endtask
  // Full and zero-bit-only read-back verification.
  task automatic t_verify;
    run(16'h00c4, 16'h0002, 8'h80);
    run(16'h00cc, 16'h0002, 8'h80);
    run(16'h20cc, 16'h0002, 8'h01);
    $display("test verify done");
  endtask
  // Two commands fill the buffer while the engine stalls; the first fails but stays silent.
  task automatic t_fill;
    hold <= 1'b1;
    flip <= 8'h01;
    send(pk(16'h0ac4, 16'h0001), 1'b0, 1'b1);
    send(pk(16'h00c4, 16'h0000), 1'b0, 1'b0);
    @(negedge ref_clk_i);
    `CHK(setup_ready_o, 1'b0)
    @(posedge ref_clk_i);
    wr(8'h00, 32'h2);
    rd(8'h04, 32'h18);
    hold <= 1'b0;
    wait_result(17'h0);
    $display("test fill done");
  endtask
  // Page read carries the token compatibility control.
  task automatic t_page;
    flip <= 8'h00;
    wr(8'h00, 32'h1);
    rd(8'h00, 32'h1);
    hold <= 1'b1;
    send(pk(16'h0000, 16'h0002), 1'b0, 1'b1);
    @(negedge ref_clk_i);
    `CHK({cmd_o.kind, cmd_o.secure_token_compat}, {ewc_pkg::EWC_KIND_PAGE, 1'b1})
    @(posedge ref_clk_i);
    hold <= 1'b0;
    wait_result(f(1'b0, 1'b0, 16'h0002, 8'h00));
    $display("test page done");
  endtask
  // Malformed packets are dropped; status, CRC, count and an unmapped place read back.
  task automatic t_reject;
    logic [15:0] bad [6] = '{16'h00d4, 16'h00c0, 16'h00c6, 16'h80c4, 16'h04c4, 16'h01c4};
    ewc_pkg::ewc_setup_type s;
    foreach (bad[i]) send(pk(bad[i], 16'h0001), 1'b1, 1'b0);
    s = pk(16'h00c4, 16'h0000);
    s.length = 16'h0001;
    send(s, 1'b1, 1'b0);
    rd(8'h04, 32'h3);
    rd(8'h08, 32'(f(1'b0, 1'b0, 16'h0002, 8'h00)) & 32'h0000_ffff);
    rd(8'h0c, 32'(n_ok));
    rd(8'h10, 32'h0);
    $display("test reject done");
  endtask
  task automatic conclude;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    t_crc();
    t_verify();
    t_fill();
    t_page();
    t_reject();
    conclude();
  end
  // Watchdog well beyond the few hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    mismatches++;
    conclude();
  end
endmodule // eprom_write_command_decode_tb
`default_nettype wire
